// ==== verilog/asr_pkg.sv ====
package asr_pkg;

  // ----------------------------------------------------------------
  // register map (word offsets on the plain port)
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL1_OFS  = 3'h0;
  localparam logic [2:0] CTRL2_OFS  = 3'h1;
  localparam logic [2:0] CTRL3_OFS  = 3'h2;
  localparam logic [2:0] STAT1_OFS  = 3'h3;
  localparam logic [2:0] DATA_OFS   = 3'h4;
  localparam logic [2:0] BAUD_OFS   = 3'h5;

  // control_reg_one fields
  localparam int C1_M     = 4;
  localparam int C1_WAKE  = 3;
  localparam int C1_IDLE_COUNT_TYPE  = 2;
  localparam int C1_PEN   = 1;
  localparam int C1_PTY   = 0;
  // control_reg_two fields
  localparam int C2_RIE   = 5;
  localparam int C2_IDLE_INT_ENABLE  = 4;
  localparam int C2_RE    = 2;
  localparam int C2_RWU   = 1;
  // control_reg_three fields
  localparam int C3_R8    = 7;
  localparam int C3_DMA   = 5;
  localparam int C3_OVERRUN_INT_ENABLE  = 3;
  localparam int C3_NOISE_INT_ENABLE  = 2;
  localparam int C3_FRAMING_INT_ENABLE  = 1;
  localparam int C3_PARITY_INT_ENABLE  = 0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // sampling
  localparam int          OVERSAMPLE  = 16;
  localparam int          CLK_HZ      = 50000000;
  localparam logic [3:0]  PH_START_A  = 4'h3;
  localparam logic [3:0]  PH_START_B  = 4'h5;
  localparam logic [3:0]  PH_START_C  = 4'h7;
  localparam logic [3:0]  PH_VOTE_A   = 4'h8;
  localparam logic [3:0]  PH_VOTE_B   = 4'h9;
  localparam logic [3:0]  PH_VOTE_C   = 4'hA;
  localparam logic [3:0]  PH_LAST     = 4'hF;
  localparam logic [3:0]  IDLE_BITS_8 = 4'hA;
  localparam logic [3:0]  IDLE_BITS_9 = 4'hB;

  // receiver sequencer states
  typedef enum logic [3:0] {
    ASR_HUNT  = 4'b0001,
    ASR_START = 4'b0010,
    ASR_DATA  = 4'b0100,
    ASR_STOP  = 4'b1000
  } asr_state_t;

  // one completed character from the sequencer
  typedef struct packed {
    logic       done;
    logic [8:0] data;
    logic       noise;
    logic       frame_err;
    logic       par_err;
  } asr_char_t;

  // status flags
  typedef struct packed {
    logic full;
    logic idle;
    logic overrun;
    logic noise;
    logic frame;
    logic parity;
  } asr_flags_t;

endpackage

// ==== verilog/asr_tick.sv ====
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// sample_phase_clock enable: 16x baud from a programmable divider
// ------------------------------------------------------------------
module asr_tick (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // divider setting, ticks every (div_i + 1) clocks
  input  wire logic [7:0] div_i,
  // one-cycle enable at 16x baud
  output logic            tick_o
);

  logic [7:0] cnt_q;
  wire        wrap = (cnt_q >= div_i);

  // free running divider; a lowered setting takes effect at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= wrap ? 8'h00 : cnt_q + 8'h01;
      tick_o <= wrap;
    end
  end

endmodule // asr_tick

`default_nettype wire

// ==== verilog/asr_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// two-stage synchroniser for the serial input pin
// ------------------------------------------------------------------
module asr_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // asynchronous pin and its synchronised copy
  input  wire logic pin_i,
  output logic      pin_o
);

  logic meta_q;

  // line idles high, so reset to one to avoid a false start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      pin_o  <= 1'b1;
    end else begin
      meta_q <= pin_i;
      pin_o  <= meta_q;
    end
  end

endmodule // asr_sync

`default_nettype wire

// ==== verilog/asr_rx.sv ====
// Contract
// - completed character data goes to the read-only buffer and sets full flag
// - full flag with rx_int_enable requests CPU interrupt, or DMA when enabled
// - input sampled on sample_phase_clock ticks at sixteen times baud
// - phase counter resyncs after start bit and on voted one-to-zero data
// - start search needs zero after three ones, then counts sixteen phases
// - phases 3,5,7 verify start; one-off patterns accepted with noise
// - failed start verification restarts the search for a start bit
// - data bit is majority of phases 8,9,10; disagreement flags noise
// - ones at start phases 8-10 flag noise but keep the start bit
// - stop bit voted; zero majority sets framing fault, disagreement noise
// - framing fault set with full flag; break character also sets it
// - standby bit holds receiver in standby and blocks receiver requests
// - address-mark wake: MSB one clears standby and sets full flag
// - idle wake clears standby without setting idle or full flag
// - idle count starts after start bit or after stop bit by type; type 1 here still counts data-bit ones and skips the start and stop votes
// - idle flag after 10 or 11 ones; may raise CPU interrupt
// - DMA enable blocks receiver CPU interrupts and idle interrupt enable
// - overrun keeps old buffer, drops new character, may raise error interrupt
// - noise in any bit sets noise flag; may raise error interrupt
// - framing and parity flags may raise error interrupts; parity checked
// - 8 or 9 bit characters; ninth bit holds bit 8 or copies bit 7
// - without DMA, full clears by status read then data read
// - with DMA, data read alone clears full, other flags untouched
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

module asr_rx (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       dma_rd_i,
  output logic      [7:0] rdata_o,
  // serial line
  input  wire logic       serial_in_pin_i,
  // requests
  output logic            rx_irq_o,
  output logic            err_irq_o,
  output logic            dma_req_o
);

  // ----------------------------------------------------------------
  // pin synchroniser and 16x tick
  // ----------------------------------------------------------------
  logic line_s;
  logic tick;
  logic [7:0] baud_q;

  asr_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (serial_in_pin_i),
    .pin_o (line_s)
  );

  asr_tick u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .div_i  (baud_q),
    .tick_o (tick)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [7:0] c3_q;
  logic [8:0] buf_q;
  asr_pkg::asr_flags_t fl_q;
  logic       stat_seen_q;

  wire nine_bit  = c1_q[asr_pkg::C1_M];
  wire wake_addr = c1_q[asr_pkg::C1_WAKE];
  wire idle_count_type      = c1_q[asr_pkg::C1_IDLE_COUNT_TYPE];
  wire par_en    = c1_q[asr_pkg::C1_PEN];
  wire par_odd   = c1_q[asr_pkg::C1_PTY];
  wire rie       = c2_q[asr_pkg::C2_RIE];
  wire idle_int_enable      = c2_q[asr_pkg::C2_IDLE_INT_ENABLE];
  wire rx_en     = c2_q[asr_pkg::C2_RE];
  wire standby   = c2_q[asr_pkg::C2_RWU];
  wire dma_en    = c3_q[asr_pkg::C3_DMA];

  // ----------------------------------------------------------------
  // sample history and majority vote
  // ----------------------------------------------------------------
  logic [3:0] ph_q;
  logic [2:0] hist_q;
  logic [2:0] vote_q;
  logic [2:0] st_q;
  logic       prev_bit_q;
  logic       line_d_q;

  // vote over the three centre samples; the third is the live one
  wire [2:0] trio     = {vote_q[1:0], line_s};
  wire       maj      = (trio[2] & trio[1]) | (trio[2] & trio[0]) | (trio[1] & trio[0]);
  wire       split    = (trio != 3'b000) && (trio != 3'b111);
  wire [2:0] st_trio  = {st_q[1:0], line_s};
  wire [1:0] st_ones  = {1'b0, st_trio[2]} + {1'b0, st_trio[1]} + {1'b0, st_trio[0]};
  wire       st_ok    = (st_ones < 2'd2);
  wire       st_noisy = (st_ones == 2'd1);
  wire       fall     = (hist_q == 3'b111) && !line_s;

  // ----------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------
  asr_pkg::asr_state_t state_q;
  logic [3:0] bit_q;
  logic [8:0] shf_q;
  logic       noise_q;
  logic [3:0] ones_q;
  asr_pkg::asr_char_t chr;

  wire       sample  = tick && rx_en;
  wire [3:0] nbits   = nine_bit ? 4'h9 : 4'h8;
  wire       at_vote = (ph_q == asr_pkg::PH_VOTE_C);
  wire [8:0] shf_in  = {maj, shf_q[8:1]};
  wire [8:0] data_al = nine_bit ? shf_q : {1'b0, shf_q[8:1]};
  wire       par_calc = ^(nine_bit ? data_al[7:0] : {1'b0, data_al[6:0]});
  wire       par_bit  = nine_bit ? data_al[8] : data_al[7];
  wire [3:0] idle_lim = nine_bit ? asr_pkg::IDLE_BITS_9 : asr_pkg::IDLE_BITS_8;
  wire       idle_hit = sample && at_vote && maj && (ones_q == idle_lim - 4'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= asr_pkg::ASR_HUNT;
      ph_q       <= 4'h0;
      hist_q     <= 3'b000;
      vote_q     <= 3'b000;
      st_q       <= 3'b000;
      bit_q      <= 4'h0;
      shf_q      <= 9'h000;
      noise_q    <= 1'b0;
      prev_bit_q <= 1'b1;
      line_d_q   <= 1'b1;
      chr        <= '0;
    end else begin
      chr.done <= 1'b0;
      if (sample) begin
        ph_q <= ph_q + 4'h1;
        line_d_q <= line_s;
        if (ph_q == asr_pkg::PH_START_A || ph_q == asr_pkg::PH_START_B) begin
          st_q <= {st_q[1:0], line_s};
        end
        if (ph_q == asr_pkg::PH_VOTE_A || ph_q == asr_pkg::PH_VOTE_B) begin
          vote_q <= {vote_q[1:0], line_s};
        end
        case (state_q)
          asr_pkg::ASR_HUNT: begin
            hist_q <= {hist_q[1:0], line_s};
            if (fall) begin
              state_q <= asr_pkg::ASR_START;
              ph_q    <= 4'h2;   // first low sample counts as phase 1
              noise_q <= 1'b0;
            end
          end
          asr_pkg::ASR_START: begin
            if (ph_q == asr_pkg::PH_START_C) begin
              if (!st_ok) begin
                state_q <= asr_pkg::ASR_HUNT;
                ph_q    <= 4'h0;
                hist_q  <= 3'b000;
              end else if (st_noisy) begin
                noise_q <= 1'b1;
              end
            end
            if (at_vote && trio != 3'b000) begin
              noise_q <= 1'b1;
            end
            if (ph_q == asr_pkg::PH_LAST) begin
              state_q    <= asr_pkg::ASR_DATA;
              ph_q       <= 4'h0;
              bit_q      <= 4'h0;
              prev_bit_q <= 1'b0;
            end
          end
          asr_pkg::ASR_DATA: begin
            if (at_vote) begin
              shf_q      <= shf_in;
              prev_bit_q <= maj;
              if (split) begin
                noise_q <= 1'b1;
              end
            end
            // a falling edge after a voted one realigns phases
            if (prev_bit_q && line_d_q && !line_s && ph_q < asr_pkg::PH_START_A) begin
              ph_q <= 4'h2;    // edge sample counts as phase 1, as at start
            end
            if (ph_q == asr_pkg::PH_LAST) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == nbits - 4'h1) begin
                state_q <= asr_pkg::ASR_STOP;
              end
            end
          end
          asr_pkg::ASR_STOP: begin
            if (at_vote) begin
              chr.done      <= 1'b1;
              chr.data      <= data_al;
              chr.noise     <= noise_q | split;
              chr.frame_err <= !maj;
              chr.par_err   <= par_en && ((par_calc ^ par_odd) != par_bit);
              state_q       <= asr_pkg::ASR_HUNT;
              hist_q        <= 3'b000;  // wait for three ones again
            end
          end
          default: begin
            state_q <= asr_pkg::ASR_HUNT;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // idle line counter
  // ----------------------------------------------------------------
  // counts voted ones; idle_count_type picks whether the start and stop bit votes count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ones_q <= 4'h0;
    end else if (sample && at_vote) begin
      if (!maj || idle_hit) begin
        ones_q <= 4'h0;
      end else if (state_q == asr_pkg::ASR_DATA || !idle_count_type) begin
        ones_q <= ones_q + 4'h1;
      end else if (state_q == asr_pkg::ASR_HUNT) begin
        ones_q <= ones_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  wire rd_stat  = rd_i && addr_i == asr_pkg::STAT1_OFS;
  wire rd_data  = rd_i && addr_i == asr_pkg::DATA_OFS;
  wire cpu_clr  = rd_data && stat_seen_q && !dma_en;
  wire dma_clr  = dma_rd_i && dma_en;
  wire addr_chr = chr.done && chr.data[nine_bit ? 8 : 7];
  wire wake_a   = standby && wake_addr && addr_chr;
  wire wake_i   = standby && !wake_addr && idle_hit;
  wire accept   = chr.done && (!standby || wake_a);
  wire ovr      = accept && fl_q.full && !cpu_clr && !dma_clr;
  wire load     = accept && !ovr;
  wire brk      = chr.data == 9'h000 && chr.frame_err;

  // ----------------------------------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_q        <= '0;
      buf_q       <= 9'h000;
      stat_seen_q <= 1'b0;
    end else begin
      if (rd_stat) begin
        stat_seen_q <= 1'b1;
      end else if (rd_data) begin
        stat_seen_q <= 1'b0;
      end
      if (cpu_clr) begin
        fl_q <= '0;
      end else if (dma_clr) begin
        fl_q.full <= 1'b0;
      end
      if (load) begin
        buf_q        <= brk ? 9'h000 : chr.data;
        fl_q.full    <= 1'b1;
        fl_q.frame   <= fl_q.frame | chr.frame_err;
        fl_q.noise   <= fl_q.noise | chr.noise;
        fl_q.parity  <= fl_q.parity | chr.par_err;
      end
      if (ovr) begin
        fl_q.overrun <= 1'b1;
      end
      if (idle_hit && !standby) begin
        fl_q.idle <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register writes and wake-up
  // ----------------------------------------------------------------
  wire [7:0] c3_rd = {nine_bit ? buf_q[8] : buf_q[7], c3_q[6:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_q   <= asr_pkg::CTRL_RST;
      c2_q   <= asr_pkg::CTRL_RST;
      c3_q   <= asr_pkg::CTRL_RST;
      baud_q <= asr_pkg::BAUD_RST;
    end else begin
      if (wr_i) begin
        case (addr_i)
          asr_pkg::CTRL1_OFS: c1_q   <= wdata_i;
          asr_pkg::CTRL2_OFS: c2_q   <= wdata_i;
          asr_pkg::CTRL3_OFS: c3_q   <= {1'b0, wdata_i[6:0]};
          asr_pkg::BAUD_OFS:  baud_q <= wdata_i;
          default: ;
        endcase
      end
      if (wake_a || wake_i) begin
        c2_q[asr_pkg::C2_RWU] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and requests
  // ----------------------------------------------------------------
  wire [7:0] stat_rd = {2'b00, fl_q.full, fl_q.idle, fl_q.overrun,
                        fl_q.noise, fl_q.frame, fl_q.parity};
  wire [7:0] rd_mux  = (addr_i == asr_pkg::CTRL1_OFS) ? c1_q :
                       (addr_i == asr_pkg::CTRL2_OFS) ? c2_q :
                       (addr_i == asr_pkg::CTRL3_OFS) ? c3_rd :
                       (addr_i == asr_pkg::STAT1_OFS) ? stat_rd :
                       (addr_i == asr_pkg::DATA_OFS)  ? buf_q[7:0] :
                       (addr_i == asr_pkg::BAUD_OFS)  ? baud_q : 8'h00;
  // receiver requests are blocked in standby and CPU ones under dma
  wire rx_irq_d  = !standby && !dma_en &&
                   ((fl_q.full && rie) || (fl_q.idle && idle_int_enable));
  wire dma_req_d = !standby && dma_en && rie && fl_q.full;
  wire err_irq_d = (fl_q.overrun && c3_q[asr_pkg::C3_OVERRUN_INT_ENABLE]) ||
                   (fl_q.noise   && c3_q[asr_pkg::C3_NOISE_INT_ENABLE]) ||
                   (fl_q.frame   && c3_q[asr_pkg::C3_FRAMING_INT_ENABLE]) ||
                   (fl_q.parity  && c3_q[asr_pkg::C3_PARITY_INT_ENABLE]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o   <= 8'h00;
      rx_irq_o  <= 1'b0;
      err_irq_o <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      rdata_o   <= rd_i ? rd_mux : 8'h00;
      rx_irq_o  <= rx_irq_d;
      err_irq_o <= err_irq_d;
      dma_req_o <= dma_req_d;
    end
  end

endmodule // asr_rx

`default_nettype wire

// ==== tb/asr_rx_checker.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// port checks of the receiver
// ----------------------------------------
module asr_rx_checker (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       dma_rd_i,
  input wire logic [7:0] rdata_o,
  // line and requests
  input wire logic       serial_in_pin_i,
  input wire logic       rx_irq_o,
  input wire logic       err_irq_o,
  input wire logic       dma_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // decoded control writes
  wire logic wr2 = wr_i && (addr_i == asr_pkg::CTRL2_OFS);
  wire logic wr3 = wr_i && (addr_i == asr_pkg::CTRL3_OFS);

  // the two steps of the cpu clear
  sequence s_stat_rd;
    rd_i && (addr_i == asr_pkg::STAT1_OFS);
  endsequence
  sequence s_data_rd;
    rd_i && (addr_i == asr_pkg::DATA_OFS);
  endsequence

  a_reset_quiet: assert property ($past(rst_i) |-> !rx_irq_o && !err_irq_o && !dma_req_o)
    else $error("requests not quiet after reset");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data without a read");
  a_cpu_or_dma: assert property (!(rx_irq_o && dma_req_o))
    else $error("cpu and dma request together");
  a_dma_off: assert property (wr3 && !wdata_i[asr_pkg::C3_DMA] |-> ##2 !dma_req_o)
    else $error("dma request with dma disabled");
  a_rx_off: assert property (wr2 && wdata_i[5:4] == 2'b00 |-> ##2 !rx_irq_o && !dma_req_o)
    else $error("receiver request while disabled");
  a_standby_mute: assert property (wr2 && wdata_i[asr_pkg::C2_RWU] |-> ##2 !rx_irq_o)
    else $error("receiver request in standby");
  a_err_off: assert property (wr3 && wdata_i[3:0] == 4'h0 |-> ##2 !err_irq_o)
    else $error("error request while disabled");
  a_clear_seq: assert property (s_stat_rd ##1 s_data_rd |-> ##[1:2] !rx_irq_o && !err_irq_o)
    else $error("flags survive the clear sequence");
  a_dma_clear: assert property (dma_rd_i && dma_req_o |-> ##[1:3] !dma_req_o)
    else $error("dma read left the request");
  a_dma_keeps: assert property (dma_rd_i && err_irq_o |=> err_irq_o)
    else $error("dma read cleared an error");
endmodule // asr_rx_checker

bind asr_rx asr_rx_checker i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .dma_rd_i(dma_rd_i), .rdata_o(rdata_o), .serial_in_pin_i(serial_in_pin_i),
  .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o), .dma_req_o(dma_req_o)
);
`default_nettype wire

// ==== tb/asr_tx_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// far-end serial transmitter
// ----------------------------------------
module asr_tx_model (
  // clock
  input  wire logic clk_i,
  // serial line, idles high
  output logic      line_o
);
  // line rests at the idle level
  initial line_o = 1'b1;

  // start, n bits lsb first, stop; bit g gets one bad sample mid-bit
  task automatic send(input logic [8:0] v, input int n, input logic stop,
                      input int bclk, input int g);
    logic b;
    for (int i = 0; i <= n + 1; i++) begin
      b = (i == 0) ? 1'b0 : (i > n) ? stop : v[i-1];
      for (int c = 0; c < bclk; c++) begin
        @(posedge clk_i);
        line_o <= (i == g && c / (bclk / 16) == 9) ? ~b : b;
      end
    end
    // ones so the next start edge follows three high samples
    @(posedge clk_i);
    line_o <= 1'b1;
    repeat (2 * bclk) @(posedge clk_i);
  endtask

  // low pulse too short to pass the start check
  task automatic blip(input int n);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (64) @(posedge clk_i);
  endtask
endmodule // asr_tx_model
`default_nettype wire

// ==== tb/asr_rx_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// receiver bench
// ----------------------------------------
module asr_rx_tb;
  localparam int         BCLK = 32; // 16 ticks of two clocks
  localparam logic [2:0] C1   = asr_pkg::CTRL1_OFS;
  localparam logic [2:0] C2   = asr_pkg::CTRL2_OFS;
  localparam logic [2:0] C3   = asr_pkg::CTRL3_OFS;
  localparam logic [2:0] ST   = asr_pkg::STAT1_OFS;
  localparam logic [2:0] DT   = asr_pkg::DATA_OFS;
  localparam logic [2:0] BD   = asr_pkg::BAUD_OFS;
  logic        clk_i;
  logic        rst_i;
  logic [2:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic        dma_rd_i;
  logic [7:0]  rdata_o;
  logic        line;
  logic        rx_irq_o;
  logic        err_irq_o;
  logic        dma_req_o;
  logic        rd_seen;
  logic [15:0] note;
  logic [15:0] expq[$];
  logic [31:0] seed = 32'h00000043;
  logic [7:0]  d;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;

  asr_rx i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .dma_rd_i(dma_rd_i), .rdata_o(rdata_o), .serial_in_pin_i(line),
    .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o), .dma_req_o(dma_req_o)
  );
  asr_tx_model i_tx (.clk_i(clk_i), .line_o(line));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // strobes stay as set until the next call, so reads can run back to back
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= w;
    rd_i    <= r;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    expq.push_back({m, e});
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  // status then data, idle bit masked
  task automatic clr(input logic [7:0] s, input logic [7:0] v);
    rd(ST, s, 8'hEF);
    rd(DT, v, 8'hFF);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask

  task automatic rx(input logic [8:0] v, input int n, input logic stop, input int g);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    i_tx.send(v, n, stop, BCLK, g);
  endtask

  task automatic irq(input logic [2:0] e);
    @(negedge clk_i);
    chk8("requests", {5'h00, e}, {5'h00, rx_irq_o, err_irq_o, dma_req_o});
  endtask

  // read data answers in the cycle after the strobe
  always @(posedge clk_i) rd_seen <= rd_i;
  always @(negedge clk_i) begin
    if (rd_seen === 1'b1) begin
      note = expq.pop_front();
      if (note[15:8] != 8'h00)
        chk8("rdata", note[7:0], rdata_o & note[15:8]);
    end
  end

  // hang guard, well above the ~6400 cycles of the sequence
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    rst_i    = 1'b1;
    addr_i   = 3'h0;
    wdata_i  = 8'h00;
    wr_i     = 1'b0;
    rd_i     = 1'b0;
    dma_rd_i = 1'b0;
    rd_seen  = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 1'b0, 3'h6, 8'hFF);
    rd(C1, 8'h00, 8'hFF);
    rd(C2, 8'h00, 8'hFF);
    rd(C3, 8'h00, 8'hFF);
    rd(ST, 8'h00, 8'hFF);
    rd(3'h6, 8'h00, 8'hFF);
    bus(1'b1, 1'b0, BD, 8'h01);
    bus(1'b1, 1'b0, C3, 8'h00);
    bus(1'b1, 1'b0, C2, 8'h04);
    bus(1'b1, 1'b0, C3, 8'h0F);
    bus(1'b1, 1'b0, C2, 8'h24);
    rd(BD, 8'h01, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      d = seed[7:0];
      rx({1'b0, d}, 8, 1'b1, -1);
      irq(3'b100);
      clr(8'h20, d);
      rd(ST, 8'h00, 8'hEF);
      rd(C3, {d[7], 7'h00}, 8'h80);
    end
    seed = xs(seed);
    d = seed[7:0];
    rx({1'b0, d}, 8, 1'b1, -1);
    rx(9'h03C, 8, 1'b1, -1);
    irq(3'b110);
    clr(8'h28, d);
    rx(9'h000, 8, 1'b0, -1);
    irq(3'b110);
    clr(8'h22, 8'h00);
    rx({1'b0, d}, 8, 1'b1, 3);
    irq(3'b110);
    clr(8'h24, d);
    bus(1'b1, 1'b0, C1, 8'h02);
    rx(9'h001, 8, 1'b1, -1);
    clr(8'h21, 8'h01);
    rx(9'h081, 8, 1'b1, -1);
    clr(8'h20, 8'h81);
    bus(1'b1, 1'b0, C1, 8'h10);
    rx(9'h155, 9, 1'b1, -1);
    clr(8'h20, 8'h55);
    rd(C3, 8'h80, 8'h80);
    bus(1'b1, 1'b0, C1, 8'h00);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    i_tx.blip(2);
    rd(ST, 8'h00, 8'hEF);
    bus(1'b1, 1'b0, C1, 8'h08);
    bus(1'b1, 1'b0, C2, 8'h26);
    rx(9'h012, 8, 1'b1, -1);
    irq(3'b000);
    rd(ST, 8'h00, 8'hEF);
    rx(9'h092, 8, 1'b1, -1);
    irq(3'b100);
    clr(8'h20, 8'h92);
    rd(C2, 8'h24, 8'hFF);
    bus(1'b1, 1'b0, C1, 8'h00);
    bus(1'b1, 1'b0, C2, 8'h34);
    rx(9'h000, 8, 1'b1, -1);
    clr(8'h20, 8'h00);
    repeat (12 * BCLK) @(posedge clk_i);
    irq(3'b100);
    rd(ST, 8'h10, 8'hFF);
    rd(DT, 8'h00, 8'h00);
    bus(1'b1, 1'b0, C3, 8'h2F);
    rx({1'b0, d}, 8, 1'b0, -1);
    irq(3'b011);
    @(posedge clk_i);
    dma_rd_i <= 1'b1;
    @(posedge clk_i);
    dma_rd_i <= 1'b0;
    repeat (12 * BCLK) @(posedge clk_i);
    irq(3'b010);
    rd(ST, 8'h02, 8'hEF);
    bus(1'b0, 1'b0, 3'h0, 8'h00);
    repeat (2) @(posedge clk_i);
    give_verdict();
  end
endmodule // asr_rx_tb
`default_nettype wire
